/* inc/mscsp_pkg.sv */
// package for the module serial configuration and scan port
// assumes a 20 MHz system clock and a host-driven shift clock
package mscsp_pkg;
  // ---------------------------------------------------------------
  // reference modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MSCSP_TWO_WIRE_RETURN = 2'b00,
    MSCSP_GROUNDED_SINGLE = 2'b01,
    MSCSP_SENSED_SINGLE = 2'b10
  } mscsp_mode_t;
  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int unsigned MSCSP_ADDR_W = 8;
  localparam int unsigned MSCSP_DATA_W = 8;
  localparam logic [7:0] MSCSP_MODULE_ADDR_RST = 8'h01;
  localparam logic [3:0] MSCSP_CMD_MODE = 4'h1;
  localparam logic [3:0] MSCSP_CMD_CHAN = 4'h2;
  localparam logic [3:0] MSCSP_CMD_STATUS = 4'h3;
  localparam int unsigned MSCSP_CMD_HI = 7;
  localparam int unsigned MSCSP_CMD_LO = 4;
  localparam int unsigned MSCSP_ARG_HI = 3;
  localparam int unsigned MSCSP_ARG_LO = 0;
  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  localparam int unsigned MSCSP_NUM_CH = 8;
  localparam logic [2:0] MSCSP_CH_FIRST = 3'h0;
  localparam logic [2:0] MSCSP_CH_LAST = 3'h7;
  localparam logic [2:0] MSCSP_CH_STEP = 3'h1;
  localparam logic [2:0] MSCSP_BIT_LAST = 3'h7;
  localparam logic [2:0] MSCSP_BIT_ZERO = 3'h0;
endpackage

/* core/mscsp_sync2.sv */
// two-flop synchroniser for a single level
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module mscsp_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

/* core/mscsp_top.sv */
// top of the module serial configuration and scan port
// assumes the host drives the shift clock, the link lines and the scan strobe
// What this block does
// - reset leaves two-wire-return mode, negatives to reference
// - grounded-single connects output ground pair only
// - sensed-single connects output sense reference line
// - cabled module drives serial output read-back
// - act only when controller slot not selected
// - one bit per shift clock, in and out
// - each scan strobe advances output channel, except in a cycle where a channel command loads it
// - eight output channels, zero to seven
`timescale 1ns/1ps
`default_nettype none
module mscsp_top
  import mscsp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SHIFT_CLK,
  input wire logic HOST_SERIAL_IN,
  input wire logic DATA_OR_ADDRESS_FLAG,
  input wire logic CONTROLLER_SLOT_SELECT_N,
  input wire logic SAMPLE_ADVANCE_STROBE,
  input wire logic CABLED_MODULE,
  output logic MODULE_SERIAL_OUT,
  output logic MODULE_SERIAL_OUT_OE,
  output logic [MSCSP_NUM_CH-1:0] NEG_LINE_TO_REF,
  output logic OUTPUT_GROUND_TO_REF,
  output logic OUTPUT_SENSE_TO_REF,
  output logic [2:0] MUX_CHANNEL
);
  // ---------------------------------------------------------------
  // link domain: shift registers on the host shift clock
  // ---------------------------------------------------------------
  logic link_rst_n;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic sel_reg;
  logic sel_next;
  logic [7:0] word_reg;
  logic [7:0] word_next;
  logic wtog_reg;
  logic wtog_next;
  logic [7:0] out_sh_reg;
  logic [7:0] out_sh_next;
  logic sout_reg;
  logic sout_next;
  logic [7:0] status_sync_a;
  logic [7:0] status_sync_b;
  logic [7:0] status_word;
  logic [7:0] status_sync_c;
  logic [7:0] status_hold_reg;
  logic [7:0] status_hold_next;
  mscsp_sync2 u_link_rst (
    .clk(SHIFT_CLK),
    .rst_n(1'b1),
    .d(RST_N),
    .q(link_rst_n)
  );
  always_comb begin
    sh_next = {sh_reg[6:0], HOST_SERIAL_IN};
    cnt_next = cnt_reg + MSCSP_CH_STEP;
    sel_next = sel_reg;
    word_next = word_reg;
    wtog_next = wtog_reg;
    if (CONTROLLER_SLOT_SELECT_N == 1'b0) begin
      cnt_next = MSCSP_BIT_ZERO;
    end else if (cnt_reg == MSCSP_BIT_LAST) begin
      word_next = sh_next;
      if (DATA_OR_ADDRESS_FLAG == 1'b0) begin
        sel_next = (sh_next == MSCSP_MODULE_ADDR_RST);
      end else if (sel_reg) begin
        wtog_next = ~wtog_reg;
      end
    end
  end
  always_ff @(posedge SHIFT_CLK) begin
    if (!link_rst_n) begin
      sh_reg <= 8'h00;
      cnt_reg <= MSCSP_BIT_ZERO;
      sel_reg <= 1'b0;
      word_reg <= 8'h00;
      wtog_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
      word_reg <= word_next;
      wtog_reg <= wtog_next;
    end
  end
  // status word crosses as a slow level; taken only after two equal samples
  always_comb begin
    status_hold_next = status_hold_reg;
    if (status_sync_b == status_sync_c) begin
      status_hold_next = status_sync_c;
    end
  end
  always_ff @(posedge SHIFT_CLK) begin
    if (!link_rst_n) begin
      status_sync_a <= 8'h00;
      status_sync_b <= 8'h00;
      status_sync_c <= 8'h00;
      status_hold_reg <= 8'h00;
    end else begin
      status_sync_a <= status_word;
      status_sync_b <= status_sync_a;
      status_sync_c <= status_sync_b;
      status_hold_reg <= status_hold_next;
    end
  end
  always_comb begin
    out_sh_next = {out_sh_reg[6:0], 1'b0};
    if (cnt_reg == MSCSP_BIT_ZERO) begin
      out_sh_next = status_hold_reg;
    end
    sout_next = out_sh_next[7];
  end
  always_ff @(negedge SHIFT_CLK) begin
    if (!link_rst_n) begin
      out_sh_reg <= 8'h00;
      sout_reg <= 1'b0;
    end else begin
      out_sh_reg <= out_sh_next;
      sout_reg <= sout_next;
    end
  end
  // ---------------------------------------------------------------
  // system domain: word handshake and strobe
  // ---------------------------------------------------------------
  logic tog_s;
  logic strobe_s;
  logic cab_s;
  logic tog_d_reg;
  logic tog_e_reg;
  logic stb_d_reg;
  logic [7:0] cmd_a_reg;
  logic [7:0] cmd_b_reg;
  mscsp_sync2 u_tog (.clk(CLK), .rst_n(RST_N), .d(wtog_reg), .q(tog_s));
  mscsp_sync2 u_stb (.clk(CLK), .rst_n(RST_N), .d(SAMPLE_ADVANCE_STROBE), .q(strobe_s));
  mscsp_sync2 u_cab (.clk(CLK), .rst_n(RST_N), .d(CABLED_MODULE), .q(cab_s));
  // word settles two edges before its toggle is used
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd_a_reg <= 8'h00;
      cmd_b_reg <= 8'h00;
      tog_d_reg <= 1'b0;
      tog_e_reg <= 1'b0;
      stb_d_reg <= 1'b0;
    end else begin
      cmd_a_reg <= word_reg;
      cmd_b_reg <= cmd_a_reg;
      tog_d_reg <= tog_s;
      tog_e_reg <= tog_d_reg;
      stb_d_reg <= strobe_s;
    end
  end
  // ---------------------------------------------------------------
  // mode and channel state
  // ---------------------------------------------------------------
  mscsp_mode_t mode_reg;
  mscsp_mode_t mode_next;
  logic [2:0] ch_reg;
  logic [2:0] ch_next;
  logic word_evt;
  logic strobe_evt;
  assign word_evt = tog_d_reg ^ tog_e_reg;
  assign strobe_evt = strobe_s & ~stb_d_reg;
  function automatic mscsp_mode_t decode_mode(input logic [3:0] arg);
    unique case (arg[1:0])
      2'b01: decode_mode = MSCSP_GROUNDED_SINGLE;
      2'b10: decode_mode = MSCSP_SENSED_SINGLE;
      default: decode_mode = MSCSP_TWO_WIRE_RETURN;
    endcase
  endfunction
  always_comb begin
    mode_next = mode_reg;
    ch_next = ch_reg;
    if (word_evt && cmd_b_reg[MSCSP_CMD_HI:MSCSP_CMD_LO] == MSCSP_CMD_MODE) begin
      mode_next = decode_mode(cmd_b_reg[MSCSP_ARG_HI:MSCSP_ARG_LO]);
    end
    if (word_evt && cmd_b_reg[MSCSP_CMD_HI:MSCSP_CMD_LO] == MSCSP_CMD_CHAN) begin
      ch_next = cmd_b_reg[2:0];
    end else if (strobe_evt) begin
      ch_next = (ch_reg == MSCSP_CH_LAST) ? MSCSP_CH_FIRST : ch_reg + MSCSP_CH_STEP;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode_reg <= MSCSP_TWO_WIRE_RETURN;
      ch_reg <= MSCSP_CH_FIRST;
    end else begin
      mode_reg <= mode_next;
      ch_reg <= ch_next;
    end
  end
  assign status_word = {MSCSP_CMD_STATUS, 1'b0, ch_reg};
  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic [MSCSP_NUM_CH-1:0] neg_reg;
  logic gnd_reg;
  logic sense_reg;
  logic [2:0] mux_reg;
  logic oe_reg;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      neg_reg <= '1;
      gnd_reg <= 1'b0;
      sense_reg <= 1'b0;
      mux_reg <= MSCSP_CH_FIRST;
      oe_reg <= 1'b0;
    end else begin
      neg_reg <= {MSCSP_NUM_CH{mode_next == MSCSP_TWO_WIRE_RETURN}};
      gnd_reg <= (mode_next == MSCSP_GROUNDED_SINGLE);
      sense_reg <= (mode_next == MSCSP_SENSED_SINGLE);
      mux_reg <= ch_next;
      oe_reg <= cab_s;
    end
  end
  assign NEG_LINE_TO_REF = neg_reg;
  assign OUTPUT_GROUND_TO_REF = gnd_reg;
  assign OUTPUT_SENSE_TO_REF = sense_reg;
  assign MUX_CHANNEL = mux_reg;
  assign MODULE_SERIAL_OUT = sout_reg;
  assign MODULE_SERIAL_OUT_OE = oe_reg;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_strobe_rise;
    strobe_evt && !(word_evt && cmd_b_reg[MSCSP_CMD_HI:MSCSP_CMD_LO] == MSCSP_CMD_CHAN);
  endsequence
  property p_wrap;
    @(posedge CLK) disable iff (!RST_N) s_strobe_rise ##0 (ch_reg == MSCSP_CH_LAST) |=> ch_reg == MSCSP_CH_FIRST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("channel did not wrap");
  property p_adv;
    @(posedge CLK) disable iff (!RST_N) s_strobe_rise ##0 (ch_reg != MSCSP_CH_LAST) |=> ch_reg == $past(ch_reg) + MSCSP_CH_STEP;
  endproperty
  a_adv: assert property (p_adv) else $error("channel did not advance");
  property p_mux;
    @(posedge CLK) disable iff (!RST_N) ##1 MUX_CHANNEL == ch_reg;
  endproperty
  a_mux: assert property (p_mux) else $error("mux output lags channel");
  property p_neg;
    @(posedge CLK) disable iff (!RST_N) ##1 (NEG_LINE_TO_REF == '1) == (mode_reg == MSCSP_TWO_WIRE_RETURN);
  endproperty
  a_neg: assert property (p_neg) else $error("negative lines wrong");
  property p_gnd;
    @(posedge CLK) disable iff (!RST_N) ##1 OUTPUT_GROUND_TO_REF == (mode_reg == MSCSP_GROUNDED_SINGLE);
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground pair wrong");
  property p_sense;
    @(posedge CLK) disable iff (!RST_N) ##1 OUTPUT_SENSE_TO_REF == (mode_reg == MSCSP_SENSED_SINGLE);
  endproperty
  a_sense: assert property (p_sense) else $error("sense reference wrong");
  property p_excl;
    @(posedge CLK) disable iff (!RST_N) !(OUTPUT_GROUND_TO_REF && OUTPUT_SENSE_TO_REF);
  endproperty
  a_excl: assert property (p_excl) else $error("two references at once");
  property p_oe;
    @(posedge CLK) disable iff (!RST_N) $rose(cab_s) |=> MODULE_SERIAL_OUT_OE;
  endproperty
  a_oe: assert property (p_oe) else $error("serial out not enabled");
  property p_sel;
    @(posedge SHIFT_CLK) disable iff (!link_rst_n) !CONTROLLER_SLOT_SELECT_N == 1'b1 |=> cnt_reg == MSCSP_BIT_ZERO && $stable(wtog_reg);
  endproperty
  a_sel: assert property (p_sel) else $error("acted on slot zero traffic");
endmodule
`default_nettype wire

/* tb/mscsp_host.sv */
// host model: drives the serial link, select, flag and scan strobe
// assumes the bench calls its tasks; shift clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module mscsp_host (
  output logic shift_clk,
  output logic serial_in,
  output logic flag,
  output logic sel_n,
  output logic strobe,
  input wire logic serial_out
);
  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    flag = 1'b0;
    sel_n = 1'b1;
    strobe = 1'b0;
  end
  // ---------------------------------------------------------------
  // one byte frame, msb first, read back captured alongside
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] b, input logic f, input logic sn, output logic [7:0] rd);
    rd = 8'h00;
    #13;
    sel_n = sn;
    flag = f;
    for (int i = 7; i >= 0; i--) begin
      serial_in = b[i];
      #32 rd = {rd[6:0], serial_out};
      shift_clk = 1'b1;
      #32 shift_clk = 1'b0;
    end
    serial_in = ~serial_in;
    sel_n = 1'b1;
  endtask
  task automatic idle_clocks(input int n);
    sel_n = 1'b0;
    repeat (n) begin
      #32 shift_clk = 1'b1;
      #32 shift_clk = 1'b0;
    end
    sel_n = 1'b1;
  endtask
  task automatic strobe_pulse();
    strobe = 1'b1;
    #200 strobe = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

/* tb/mscsp_top_bench.sv */
// self-checking bench for the serial config and scan port
// assumes mscsp_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module mscsp_top_bench;
  import mscsp_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CABLED_MODULE = 1'b0;
  logic sclk, sdi, flg, seln, stb, sdo, sdo_oe, gnd_ref, sense_ref;
  logic [7:0] neg_ref;
  logic [2:0] mux;
  logic [12:0] exp_q[$];
  logic [12:0] prev;
  logic [7:0] rd;
  mscsp_mode_t exp_mode;
  logic [2:0] exp_ch;
  int error_cnt = 0;
  int cmp_count = 0;
  wire logic [12:0] outs = {neg_ref, gnd_ref, sense_ref, mux};
  always #25 CLK = ~CLK;
  wire logic host_sdo = sdo_oe ? sdo : ~sdo;
  mscsp_host host (.shift_clk(sclk), .serial_in(sdi), .flag(flg), .sel_n(seln), .strobe(stb), .serial_out(host_sdo));
  mscsp_top dut (.CLK(CLK), .RST_N(RST_N), .SHIFT_CLK(sclk), .HOST_SERIAL_IN(sdi), .DATA_OR_ADDRESS_FLAG(flg),
    .CONTROLLER_SLOT_SELECT_N(seln), .SAMPLE_ADVANCE_STROBE(stb), .CABLED_MODULE(CABLED_MODULE),
    .MODULE_SERIAL_OUT(sdo), .MODULE_SERIAL_OUT_OE(sdo_oe), .NEG_LINE_TO_REF(neg_ref),
    .OUTPUT_GROUND_TO_REF(gnd_ref), .OUTPUT_SENSE_TO_REF(sense_ref), .MUX_CHANNEL(mux));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] enc(input mscsp_mode_t m, input logic [2:0] c);
    return {(m == MSCSP_TWO_WIRE_RETURN) ? 8'hff : 8'h00, m == MSCSP_GROUNDED_SINGLE, m == MSCSP_SENSED_SINGLE, c};
  endfunction
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic note(input mscsp_mode_t m, input logic [2:0] c);
    if (enc(m, c) !== enc(exp_mode, exp_ch)) exp_q.push_back(enc(m, c));
    exp_mode = m;
    exp_ch = c;
  endtask
  task automatic send(input logic [7:0] b, input logic f, input logic sn);
    host.xfer(b, f, sn, rd);
    #500;
  endtask
  task automatic cmd(input logic [7:0] b);
    mscsp_mode_t m;
    logic [2:0] c;
    m = exp_mode;
    c = exp_ch;
    if (b[7:4] == MSCSP_CMD_MODE) begin
      m = (b[3:0] == 4'h1) ? MSCSP_GROUNDED_SINGLE : (b[3:0] == 4'h2) ? MSCSP_SENSED_SINGLE : MSCSP_TWO_WIRE_RETURN;
    end
    if (b[7:4] == MSCSP_CMD_CHAN) c = b[2:0];
    note(m, c);
    send(b, 1'b1, 1'b1);
  endtask
  task automatic adv();
    note(exp_mode, exp_ch + 3'h1);
    @(posedge CLK);
    #2 host.strobe_pulse();
  endtask
  // ---------------------------------------------------------------
  // output monitor: each change takes the oldest note
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST_N === 1'b1 && outs !== prev) begin
      if (exp_q.size() == 0) check(outs, prev);
      else check(outs, exp_q.pop_front());
    end
    prev <= outs;
  end
  initial begin
    #3_000_000;
    error_cnt++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h8534_d093));
    exp_mode = MSCSP_TWO_WIRE_RETURN;
    exp_ch = 3'h0;
    fork
      host.idle_clocks(4);
    join_none
    repeat (20) @(posedge CLK);
    #2 RST_N = 1'b1;
    repeat (3) @(posedge CLK);
    check(outs, enc(MSCSP_TWO_WIRE_RETURN, 3'h0));
    check({12'h000, sdo_oe}, 13'h0000);
    host.idle_clocks(4);
    send(MSCSP_MODULE_ADDR_RST, 1'b0, 1'b1);
    cmd({MSCSP_CMD_MODE, 4'h1});
    cmd({MSCSP_CMD_MODE, 4'h2});
    check({12'h000, sense_ref}, 13'h0001);
    cmd({MSCSP_CMD_MODE, 4'h3});
    cmd({MSCSP_CMD_MODE, 4'h2});
    cmd({MSCSP_CMD_MODE, 4'h0});
    send({MSCSP_CMD_MODE, 4'h1}, 1'b1, 1'b0);
    send(8'h05, 1'b0, 1'b1);
    send({MSCSP_CMD_MODE, 4'h1}, 1'b1, 1'b1);
    send(8'h11, 1'b0, 1'b1);
    send({MSCSP_CMD_MODE, 4'h2}, 1'b1, 1'b1);
    send(MSCSP_MODULE_ADDR_RST, 1'b0, 1'b1);
    cmd({MSCSP_CMD_CHAN, 4'h6});
    repeat (10) adv();
    repeat (4) cmd({MSCSP_CMD_CHAN, 1'b0, 3'($urandom_range(7))});
    @(posedge CLK);
    #2 CABLED_MODULE = 1'b1;
    repeat (5) @(posedge CLK);
    check({12'h000, sdo_oe}, 13'h0001);
    repeat (2) send({MSCSP_CMD_STATUS, 4'h0}, 1'b1, 1'b1);
    check({5'h00, rd}, {5'h00, MSCSP_CMD_STATUS, 1'b0, exp_ch});
    #1000;
    check(13'(exp_q.size()), 13'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
